// >>> src/usr8_pkg.sv
// Constants, types and register map of the eight-stage universal shift register
package usr8_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned STAGE_W = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;

  // ------------------------------------------------------------
  // Operating modes, code is {select1, select0}, Gray along the path
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_HOLD        = 2'h0,
    MODE_SHIFT_RIGHT = 2'h1,
    MODE_LOAD        = 2'h3,
    MODE_SHIFT_LEFT  = 2'h2
  } mode_t;

  // ------------------------------------------------------------
  // Register offsets (byte addresses on the APB port)
  // ------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_DATA   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int unsigned CTRL_STEP_BIT    = 0;
  localparam int unsigned CTRL_PINCLK_BIT  = 1;
  localparam int unsigned STATUS_MODE_LSB  = 0;
  localparam int unsigned STATUS_DRIVE_BIT = 2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [STAGE_W-1:0] STAGES_RESET = 8'h00;
  localparam logic               PINCLK_RESET = 1'b1;
  localparam logic [DATA_W-1:0]  RDATA_RESET  = 32'h0000_0000;

endpackage

// >>> src/stage_bus_if.sv
// Carrier between the control logic and the stage bank
`timescale 1ns/10ps
`default_nettype none

interface stage_bus_if;
  import usr8_pkg::*;

  mode_t               mode;        // Selected operating mode
  logic                step;        // One-cycle pulse: act on the stages
  logic                rightSerial; // Serial bit entering stage A
  logic                leftSerial;  // Serial bit entering stage H
  logic [STAGE_W-1:0]  loadData;    // Levels on the parallel terminals
  logic [STAGE_W-1:0]  stages;      // Current stage contents, A in bit 0

  modport ctrl (output mode, output step, output rightSerial, output leftSerial,
                output loadData, input stages);
  modport bank (input mode, input step, input rightSerial, input leftSerial,
                input loadData, output stages);
endinterface

`default_nettype wire

// >>> src/stage_bank.sv
// Eight storage stages with hold, shift right, shift left and load
`timescale 1ns/10ps
`default_nettype none

module stage_bank (
  input  wire logic  mclk,
  input  wire logic  rst,
  input  wire logic  asyncClearN,
  stage_bus_if.bank  bus
);
  import usr8_pkg::*;

  // ------------------------------------------------------------
  // Next-value function
  // ------------------------------------------------------------
  function automatic logic [STAGE_W-1:0] nextStages(
    input mode_t              m,
    input logic [STAGE_W-1:0] cur,
    input logic               rIn,
    input logic               lIn,
    input logic [STAGE_W-1:0] par
  );
    logic [STAGE_W-1:0] res;
    res = cur;
    unique case (m)
      MODE_HOLD:        res = cur;
      MODE_SHIFT_RIGHT: res = {cur[STAGE_W-2:0], rIn};
      MODE_SHIFT_LEFT:  res = {lIn, cur[STAGE_W-1:1]};
      MODE_LOAD:        res = par;
    endcase
    return res;
  endfunction

  logic [STAGE_W-1:0] stages;
  assign bus.stages = stages;

  // ------------------------------------------------------------
  // Stage register
  // ------------------------------------------------------------
  // clear without clock
  always_ff @(posedge mclk or negedge asyncClearN) begin
    if (!asyncClearN) begin
      stages <= STAGES_RESET;
    end else if (rst) begin
      stages <= STAGES_RESET;
    end else if (bus.step) begin
      stages <= nextStages(bus.mode, stages, bus.rightSerial, bus.leftSerial,
                           bus.loadData);
    end
  end

endmodule

`default_nettype wire

// >>> src/usr8_top.sv
// Top of the eight-stage universal shift register with APB access
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Two select inputs choose hold, shift right, shift left or load.
// - Eight stages A to H, each tied to its own two-way terminal.
// - Clear low empties all stages and serial outputs at once.
// - Either disable input high turns all parallel drivers off.
// - Disabled drivers leave shifting, loading, holding and clearing untouched.
// - Hold keeps every stage and all outputs unchanged across edges.
// - Shift right feeds stage A from right input; left feeds H.
// - Load captures terminals A to H; drivers stay off while loading.
module usr8_top (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  // Device pins
  input  wire logic                    modeSelect0,
  input  wire logic                    modeSelect1,
  input  wire logic                    outputDisable1N,
  input  wire logic                    outputDisable2N,
  input  wire logic                    asyncClearN,
  input  wire logic                    leftSerialIn,
  input  wire logic                    rightSerialIn,
  input  wire logic                    shiftClock,
  input  wire logic [usr8_pkg::STAGE_W-1:0] parallelIoIn,
  output logic      [usr8_pkg::STAGE_W-1:0] parallelIoOut,
  output logic                         parallelIoOe,
  output logic                         firstStageSerialOut,
  output logic                         lastStageSerialOut,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [usr8_pkg::ADDR_W-1:0] paddr,
  input  wire logic [usr8_pkg::DATA_W-1:0] pwdata,
  output logic      [usr8_pkg::DATA_W-1:0] prdata,
  output logic                         pready,
  output logic                         pslverr
);
  import usr8_pkg::*;

  stage_bus_if bus ();

  mode_t mode;
  logic  prevShiftClock;
  logic  pinEdge;
  logic  swStep;
  logic  pinClockOn;
  logic  driveOn;
  logic  setupPhase;
  logic  accessPhase;
  logic  mapped;

  // ------------------------------------------------------------
  // Mode selection
  // ------------------------------------------------------------
  // select pins to mode
  assign mode = mode_t'({modeSelect1, modeSelect0});

  // ------------------------------------------------------------
  // Shift clock edge detection
  // ------------------------------------------------------------
  // Previous level of the shift clock pin
  always_ff @(posedge mclk) begin
    if (rst) begin
      prevShiftClock <= 1'b0;
    end else begin
      prevShiftClock <= shiftClock;
    end
  end

  assign pinEdge = shiftClock && !prevShiftClock && pinClockOn;

  // ------------------------------------------------------------
  // Stage bank connection
  // ------------------------------------------------------------
  // step ignores drivers
  assign bus.mode        = mode;
  assign bus.step        = pinEdge || swStep;
  assign bus.rightSerial = rightSerialIn;
  assign bus.leftSerial  = leftSerialIn;
  assign bus.loadData    = parallelIoIn;

  stage_bank u_bank (
    .mclk        (mclk),
    .rst         (rst),
    .asyncClearN (asyncClearN),
    .bus         (bus)
  );

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  // drive only with both disables low and not in load
  assign driveOn = !outputDisable1N && !outputDisable2N && (mode != MODE_LOAD);
  assign parallelIoOe = driveOn;
  assign parallelIoOut = bus.stages;
  assign firstStageSerialOut = bus.stages[0];
  assign lastStageSerialOut  = bus.stages[STAGE_W-1];

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign mapped      = (paddr == ADDR_DATA) || (paddr == ADDR_CTRL) ||
                       (paddr == ADDR_STATUS);
  assign pready      = 1'b1;                 // No wait states
  assign pslverr     = accessPhase && !mapped;

  // Software step pulse and pin clock gate
  always_ff @(posedge mclk) begin
    if (rst) begin
      swStep     <= 1'b0;
      pinClockOn <= PINCLK_RESET;
    end else begin
      swStep <= 1'b0;
      if (accessPhase && pwrite && (paddr == ADDR_CTRL)) begin
        swStep     <= pwdata[CTRL_STEP_BIT];
        pinClockOn <= pwdata[CTRL_PINCLK_BIT];
      end
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= RDATA_RESET;
    end else if (setupPhase && !pwrite) begin
      prdata <= RDATA_RESET;
      if (paddr == ADDR_DATA) begin
        prdata[STAGE_W-1:0] <= bus.stages;
      end else if (paddr == ADDR_CTRL) begin
        prdata[CTRL_PINCLK_BIT] <= pinClockOn;
      end else if (paddr == ADDR_STATUS) begin
        prdata[STATUS_MODE_LSB +: 2] <= mode;
        prdata[STATUS_DRIVE_BIT]     <= driveOn;
      end
    end
  end

endmodule

`default_nettype wire

// >>> testbench/usr8_monitor.sv
// Port checker for the shift register top
`timescale 1ns/10ps
`default_nettype none

module usr8_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        modeSelect0,
  input wire logic        modeSelect1,
  input wire logic        outputDisable1N,
  input wire logic        outputDisable2N,
  input wire logic        asyncClearN,
  input wire logic        leftSerialIn,
  input wire logic        rightSerialIn,
  input wire logic        shiftClock,
  input wire logic [7:0]  parallelIoIn,
  input wire logic [7:0]  parallelIoOut,
  input wire logic        parallelIoOe,
  input wire logic        firstStageSerialOut,
  input wire logic        lastStageSerialOut,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic       prevClk;
  logic [1:0] md;
  logic       pinAct;
  logic       swStep;
  logic       swStepD;
  // Pin edge and software step detection
  always_ff @(posedge mclk) prevClk <= shiftClock;
  // Step register acts one edge after the write is taken
  always_ff @(posedge mclk) swStepD <= swStep;
  assign md     = {modeSelect1, modeSelect0};
  assign pinAct = shiftClock && !prevClk && asyncClearN;
  assign swStep = psel && penable && pwrite && paddr == 12'h004 && pwdata[0];
  AST_OE: assert property (parallelIoOe == (!outputDisable1N && !outputDisable2N && md != 2'h3))
    else $error("driver enable wrong");
  AST_CLR: assert property (!asyncClearN |-> parallelIoOut == 8'h00 && !firstStageSerialOut)
    else $error("clear did not empty stages");
  AST_SERA: assert property (firstStageSerialOut == parallelIoOut[0])
    else $error("first serial out wrong");
  AST_SERH: assert property (lastStageSerialOut == parallelIoOut[7])
    else $error("last serial out wrong");
  AST_SR: assert property (pinAct && md == 2'h1 ##1 asyncClearN |->
    parallelIoOut == {$past(parallelIoOut[6:0]), $past(rightSerialIn)}) else $error("shift right wrong");
  AST_SL: assert property (pinAct && md == 2'h2 ##1 asyncClearN |->
    parallelIoOut == {$past(leftSerialIn), $past(parallelIoOut[7:1])}) else $error("shift left wrong");
  AST_LD: assert property (pinAct && md == 2'h3 ##1 asyncClearN |->
    parallelIoOut == $past(parallelIoIn)) else $error("load wrong");
  AST_HOLD: assert property ((md == 2'h0 || !pinAct && !swStepD) && asyncClearN ##1 asyncClearN
    |-> $stable(parallelIoOut)) else $error("stages changed without action");
  cover property (pinAct && md == 2'h1);
  cover property (pinAct && md == 2'h3);
  cover property (!asyncClearN);
  cover property (swStepD && md == 2'h1);
endmodule

bind usr8_top usr8_monitor chk_u (.*);

`default_nettype wire

// >>> testbench/bus_partner.sv
// Far-side logic sharing the parallel terminals
`timescale 1ns/10ps
`default_nettype none

module bus_partner (
  input  wire logic       parallelIoOe,
  input  wire logic [7:0] parallelIoOut,
  input  wire logic       driveReq,
  input  wire logic [7:0] driveVal,
  output logic      [7:0] busLevel
);
  // drives only while device is off
  assign busLevel = parallelIoOe ? parallelIoOut : (driveReq ? driveVal : 8'h00); // Pull-down
endmodule

`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the shift register top
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import usr8_pkg::*;
  logic        mclk = 0, rst = 1, clrN = 1, sck = 0, sl = 0, sr = 0, d1 = 0, d2 = 0;
  logic        drv = 0, psel = 0, penable = 0, pwrite = 0, sv = 0, rv = 0;
  logic        oe, so0, so7, pready, pslverr;
  logic [1:0]  md = 0;
  logic [7:0]  dv = 0, bus, pOut, m = 0, e8;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [32:0] rd = 0;
  logic [7:0]  q8[$];
  logic [32:0] qa[$];
  int          bad_count = 0, checks = 0, seed = 32'h861e4897;
  always #5 mclk = ~mclk;
  usr8_top dut_u (.mclk(mclk), .rst(rst), .modeSelect0(md[0]), .modeSelect1(md[1]),
    .outputDisable1N(d1), .outputDisable2N(d2), .asyncClearN(clrN), .leftSerialIn(sl),
    .rightSerialIn(sr), .shiftClock(sck), .parallelIoIn(bus), .parallelIoOut(pOut),
    .parallelIoOe(oe), .firstStageSerialOut(so0), .lastStageSerialOut(so7), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  bus_partner far_u (.parallelIoOe(oe), .parallelIoOut(pOut), .driveReq(drv),
    .driveVal(dv), .busLevel(bus));
  task automatic cmp(input string n, input logic [32:0] e, input logic [32:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Watcher: oldest note against each flagged result
  always @(negedge mclk) begin
    if (sv) begin
      e8 = q8.pop_front();
      cmp("stages", e8, pOut);
      cmp("serial", {e8[7], e8[0]}, {so7, so0});
    end
    if (rv) cmp("rdata", qa.pop_front(), rd);
  end
  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; wrap_up(); end
    rd <= {pslverr, prdata};
    if (!w) qa.push_back(e);
    rv <= !w; psel <= 0; penable <= 0;
    @(posedge mclk);
    rv <= 0;
  endtask
  // One pin clock pulse in mode mo, disables random
  task automatic act(input logic [1:0] mo, input logic dis);
    logic r, l;
    logic [7:0] p;
    r = $random(seed); l = $random(seed); p = $random(seed);
    md <= mo; sr <= r; sl <= l; dv <= p; d1 <= dis; d2 <= dis & r;
    drv <= dis || mo == 2'h3; sck <= 1;
    @(posedge mclk);
    sck <= 0;
    case (mo)
      2'h1: m = {m[6:0], r};
      2'h2: m = {l, m[7:1]};
      2'h3: m = p;
      default: m = m;
    endcase
    q8.push_back(m); sv <= 1;
    @(posedge mclk);
    sv <= 0;
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    apb(0, ADDR_DATA, 0, 33'h0);
    apb(0, ADDR_CTRL, 0, 33'h2);
    for (int i = 0; i < 80; i++) act(2'(i), 1'($random(seed)));
    // Clear in load mode with drivers off
    md <= 2'h3; d1 <= 1; clrN <= 0; m = 0;
    @(posedge mclk);
    q8.push_back(m); sv <= 1;
    @(posedge mclk);
    sv <= 0; clrN <= 1; md <= 2'h1; sr <= 1; d1 <= 0; d2 <= 0; drv <= 0;
    apb(1, ADDR_CTRL, 32'h3, 0);
    m = {m[6:0], 1'b1};
    apb(0, ADDR_DATA, 0, {25'h0, m});
    apb(0, ADDR_STATUS, 0, 33'h5);
    apb(0, 12'h00c, 0, {1'b1, 32'h0});
    wrap_up();
  end
endmodule

`default_nettype wire
